// [rtl/ocf_pkg.sv]
// Constants, preset tables and state type for the oscillator frequency configurator.
package ocf_pkg;

  // ----------------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ     = 20_000_000;
  localparam int unsigned SCL_FREQ_HZ    = 97_600;
  localparam int unsigned PHASES_PER_BIT = 4;
  // Rounded down, so the serial clock never runs slower than intended.
  localparam int unsigned QUARTER_CYCLES =
    SYS_CLK_HZ / (SCL_FREQ_HZ * PHASES_PER_BIT);

  // ----------------------------------------------------------------------
  // Oscillator bus address and registers
  // ----------------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR      = 7'h00;
  localparam logic       WRITE_FLAG      = 1'b0;
  localparam logic [7:0] ADDR_WRITE      = {SLAVE_ADDR, WRITE_FLAG};
  localparam logic [7:0] REG_DIVIDER     = 8'h07;
  localparam logic [7:0] REG_CONTROL     = 8'h87;
  localparam logic [7:0] REG_FREEZE      = 8'h89;
  localparam int unsigned FREEZE_BIT_POS = 4;
  localparam int unsigned NEWSET_BIT_POS = 6;
  localparam logic [7:0] FREEZE_ON       = 8'(1 << FREEZE_BIT_POS);
  localparam logic [7:0] FREEZE_OFF      = 8'h00;
  localparam logic [7:0] APPLY_NEW_ON    = 8'(1 << NEWSET_BIT_POS);

  // ----------------------------------------------------------------------
  // Byte sequence: four write frames, seventeen bytes in all
  // ----------------------------------------------------------------------
  localparam logic [4:0] IDX_FREEZE_REG  = 5'h01;
  localparam logic [4:0] IDX_FREEZE_VAL  = 5'h02;
  localparam logic [4:0] IDX_DIV_ADDR    = 5'h03;
  localparam logic [4:0] IDX_DIV_REG     = 5'h04;
  localparam logic [4:0] IDX_DATA_FIRST  = 5'h05;
  localparam logic [4:0] IDX_DATA_LAST   = 5'h0A;
  localparam logic [4:0] IDX_THAW_ADDR   = 5'h0B;
  localparam logic [4:0] IDX_THAW_REG    = 5'h0C;
  localparam logic [4:0] IDX_THAW_VAL    = 5'h0D;
  localparam logic [4:0] IDX_APPLY_ADDR  = 5'h0E;
  localparam logic [4:0] IDX_APPLY_REG   = 5'h0F;
  localparam logic [4:0] IDX_APPLY_VAL   = 5'h10;
  localparam logic [4:0] IDX_START       = 5'h00;

  // ----------------------------------------------------------------------
  // Preset tables, indexed by frequency_select (entry 7 leftmost)
  // ----------------------------------------------------------------------
  localparam logic [7:0][2:0] HSDIV_TAB = {
    3'h5, 3'h0, 3'h0, 3'h5, 3'h7, 3'h5, 3'h7, 3'h5};
  localparam logic [7:0][6:0] OUTDIV_TAB = {
    7'h05, 7'h01, 7'h03, 7'h01, 7'h01, 7'h03, 7'h03, 7'h05};
  localparam logic [7:0][37:0] REFMUL_TAB = {
    38'h02F40135A9, 38'h02D1E127AF, 38'h02D1E127AF, 38'h0313814290,
    38'h0302013B65, 38'h0313814290, 38'h0302013B65, 38'h02F40135A9};

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_BIT, ST_ACK, ST_STOP
  } ocf_state_e;

endpackage

// [rtl/ocf_clock_divider.sv]
// Quarter-bit tick generator that paces the serial bus engine.
`timescale 1ns/10ps
`default_nettype none
module ocf_clock_divider #(
  parameter int unsigned DIV = 51
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Tick out
  output var  logic tick
);

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] count;
  wire           wrap = (count == LAST);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      count <= wrap ? '0 : count + 1'b1;
      tick  <= wrap;
    end
  end

endmodule
`default_nettype wire

// [rtl/ocf_config_top.sv]
// Serial-bus master that programs a clock oscillator to a preset frequency.
//
// Overview of operation
// - Serial clock comes from dividing the system clock to about 97.6 kHz.
// - Reset is synchronous; low holds the module in reset, high runs.
// - A configuration starts on a rising edge of the request, never on level.
// - Done output is low during configuration and high once it has finished.
// - Three-bit select picks one of seven presets; the eighth falls back.
// - Select value six uses the 644.53125 MHz table entry.
// - Preset values become register bytes, written out over the two-wire bus.
// - Data line is two-way open drain; clock line is driven only here.
// - An initial trigger configures default settings without a user request.
// - Freeze the core, write registers 7 to 12, thaw, then apply setting.
// - Oscillator is addressed at zero, bus rate stays below 400 kbps.
// - Divider and multiplier fields are packed into registers 7 to 12.
`timescale 1ns/10ps
`default_nettype none
module ocf_config_top
  import ocf_pkg::*;
#(
  parameter int unsigned QUARTER_DIV = QUARTER_CYCLES
) (
  // Clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       RST_B,
  // User control
  input  wire logic       CONFIGURE_REQUEST,
  input  wire logic [2:0] FREQUENCY_SELECT,
  input  wire logic       INITIAL_ENABLE,
  output var  logic       CONFIG_DONE,
  output var  logic       ACK_ERROR,
  // Serial bus
  output var  logic       I2C_SCL,
  input  wire logic       I2C_SDA_IN,
  output var  logic       I2C_SDA_OUT,
  output var  logic       I2C_SDA_OE
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  ocf_state_e state;
  ocf_state_e next_state;
  logic [1:0] phase;
  logic [1:0] next_phase;
  logic [2:0] bit_idx;
  logic [2:0] next_bit_idx;
  logic [4:0] byte_idx;
  logic [4:0] next_byte_idx;
  logic [2:0] mode;
  logic       request_prev;
  logic       init_pending;
  logic       next_scl;
  logic       next_sda_oe;
  logic       next_done;
  logic       nack_seen;
  logic       tick;
  logic [7:0] cur_byte;

  ocf_clock_divider #(
    .DIV (QUARTER_DIV)
  ) u_divider (
    .clk   (CLK_SYS),
    .rst_b (RST_B),
    .tick  (tick)
  );

  // ----------------------------------------------------------------------
  // Launch decode
  // ----------------------------------------------------------------------
  wire idle       = (state == ST_IDLE);
  wire request_up = CONFIGURE_REQUEST & ~request_prev;
  wire init_go    = init_pending & INITIAL_ENABLE;
  // requests while busy are ignored, so the user must wait for done
  wire launch     = idle & (request_up | init_go);

  // ----------------------------------------------------------------------
  // Register value generator
  // ----------------------------------------------------------------------
  // fixed preset table per mode
  // select value seven repeats the mode zero entry
  // mode six takes the table value
  wire [2:0]  high_speed_divider  = HSDIV_TAB[mode];
  wire [6:0]  out_div = OUTDIV_TAB[mode];
  wire [37:0] ref_mul = REFMUL_TAB[mode];
  wire [7:0]  div_byte0 = {high_speed_divider, out_div[6:2]};
  wire [7:0]  div_byte1 = {out_div[1:0], ref_mul[37:32]};

  // every frame opens with the zero address
  always_comb begin
    cur_byte = 8'h00;
    case (byte_idx)
      IDX_START, IDX_DIV_ADDR,
      IDX_THAW_ADDR, IDX_APPLY_ADDR: cur_byte = ADDR_WRITE;
      IDX_FREEZE_REG, IDX_THAW_REG:  cur_byte = REG_FREEZE;
      IDX_FREEZE_VAL:                cur_byte = FREEZE_ON;
      IDX_DIV_REG:                   cur_byte = REG_DIVIDER;
      IDX_DATA_FIRST:                cur_byte = div_byte0;
      IDX_DATA_FIRST + 5'h01:        cur_byte = div_byte1;
      IDX_DATA_FIRST + 5'h02:        cur_byte = ref_mul[31:24];
      IDX_DATA_FIRST + 5'h03:        cur_byte = ref_mul[23:16];
      IDX_DATA_FIRST + 5'h04:        cur_byte = ref_mul[15:8];
      IDX_DATA_LAST:                 cur_byte = ref_mul[7:0];
      IDX_THAW_VAL:                  cur_byte = FREEZE_OFF;
      IDX_APPLY_REG:                 cur_byte = REG_CONTROL;
      IDX_APPLY_VAL:                 cur_byte = APPLY_NEW_ON;
      default:                       cur_byte = 8'h00;
    endcase
  end

  wire frame_end = (byte_idx == IDX_FREEZE_VAL) |
                   (byte_idx == IDX_DATA_LAST)  |
                   (byte_idx == IDX_THAW_VAL)   |
                   (byte_idx == IDX_APPLY_VAL);
  wire seq_end   = (byte_idx == IDX_APPLY_VAL);
  wire cur_bit   = cur_byte[bit_idx];

  // ----------------------------------------------------------------------
  // Bus engine
  // ----------------------------------------------------------------------
  // Each bit spends four ticks: set data, clock up, hold/sample, clock down.
  // Data therefore changes only while the clock is low, except in the start
  // and stop conditions where that is the point.
  wire last_phase = (phase == 2'h3);
  wire sample_pt  = tick & (phase == 2'h2);

  always_comb begin
    next_state    = state;
    next_phase    = phase;
    next_bit_idx  = bit_idx;
    next_byte_idx = byte_idx;
    next_scl      = I2C_SCL;
    next_sda_oe   = I2C_SDA_OE;
    next_done     = CONFIG_DONE;
    case (state)
      ST_IDLE: begin
        next_scl    = 1'b1;
        next_sda_oe = 1'b0;
        if (launch) begin
          next_state    = ST_START;
          next_phase    = 2'h0;
          next_byte_idx = IDX_START;
          // done drops for the whole run
          next_done     = 1'b0;
        end
      end
      ST_START: begin
        if (tick) begin
          next_phase = phase + 2'h1;
          case (phase)
            2'h0: begin
              next_scl    = 1'b1;
              next_sda_oe = 1'b0;
            end
            2'h1: next_sda_oe = 1'b1;
            2'h2: next_scl    = 1'b0;
            default: begin
              next_state   = ST_BIT;
              next_bit_idx = 3'h7;
            end
          endcase
        end
      end
      ST_BIT: begin
        if (tick) begin
          next_phase = phase + 2'h1;
          case (phase)
            // open drain, drive only to send a zero
            2'h0: next_sda_oe = ~cur_bit;
            2'h1: next_scl    = 1'b1;
            2'h2: next_scl    = 1'b1;
            default: begin
              next_scl = 1'b0;
              if (bit_idx == 3'h0)
                next_state = ST_ACK;
              else
                next_bit_idx = bit_idx - 3'h1;
            end
          endcase
        end
      end
      ST_ACK: begin
        if (tick) begin
          next_phase = phase + 2'h1;
          case (phase)
            2'h0: next_sda_oe = 1'b0;
            2'h1: next_scl    = 1'b1;
            2'h2: next_scl    = 1'b1;
            default: begin
              next_scl = 1'b0;
              if (frame_end) begin
                next_state = ST_STOP;
              end else begin
                next_state    = ST_BIT;
                next_bit_idx  = 3'h7;
                next_byte_idx = byte_idx + 5'h01;
              end
            end
          endcase
        end
      end
      ST_STOP: begin
        if (tick) begin
          next_phase = phase + 2'h1;
          case (phase)
            2'h0: next_sda_oe = 1'b1;
            2'h1: next_scl    = 1'b1;
            2'h2: next_sda_oe = 1'b0;
            default: begin
              if (seq_end) begin
                next_state = ST_IDLE;
                // done rises after the apply frame
                next_done  = 1'b1;
              end else begin
                next_state    = ST_START;
                next_byte_idx = byte_idx + 5'h01;
              end
            end
          endcase
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // acknowledge sampled with the ninth clock high
  assign nack_seen = (state == ST_ACK) & sample_pt & I2C_SDA_IN;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // synchronous active-low reset
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      state        <= ST_IDLE;
      phase        <= 2'h0;
      bit_idx      <= 3'h7;
      byte_idx     <= IDX_START;
      I2C_SCL      <= 1'b1;
      I2C_SDA_OE   <= 1'b0;
      CONFIG_DONE  <= 1'b1;
      request_prev <= 1'b1;
    end else begin
      state        <= next_state;
      phase        <= next_phase;
      bit_idx      <= next_bit_idx;
      byte_idx     <= next_byte_idx;
      I2C_SCL      <= next_scl;
      I2C_SDA_OE   <= next_sda_oe;
      CONFIG_DONE  <= next_done;
      request_prev <= CONFIGURE_REQUEST;
    end
  end

  // Mode is latched at launch so a select change mid-run cannot tear a frame.
  // latched mode feeds the byte generator
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      mode         <= 3'h0;
      init_pending <= 1'b1;
      ACK_ERROR    <= 1'b0;
      I2C_SDA_OUT  <= 1'b0;
    end else begin
      if (launch)
        mode <= FREQUENCY_SELECT;
      if (launch)
        init_pending <= 1'b0;
      // A missing acknowledge is flagged; the run still completes.
      if (nack_seen)
        ACK_ERROR <= 1'b1;
      else if (launch)
        ACK_ERROR <= 1'b0;
      I2C_SDA_OUT <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [tb/ocf_config_props.sv]
// Port-level concurrent checks for the oscillator configurator.
`timescale 1ns/10ps
`default_nettype none
module ocf_config_props #(
  parameter int unsigned QUARTER_DIV = 2
) (
  // Clock and reset
  input wire logic       CLK_SYS,
  input wire logic       RST_B,
  // User control
  input wire logic       CONFIGURE_REQUEST,
  input wire logic [2:0] FREQUENCY_SELECT,
  input wire logic       INITIAL_ENABLE,
  input wire logic       CONFIG_DONE,
  input wire logic       ACK_ERROR,
  // Serial bus
  input wire logic       I2C_SCL,
  input wire logic       I2C_SDA_IN,
  input wire logic       I2C_SDA_OUT,
  input wire logic       I2C_SDA_OE
);
  // ----------------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------------
  // A run is 644 quarters plus alignment, so the bounds leave some slack.
  localparam int unsigned LOW_MAX = 650 * QUARTER_DIV;
  localparam int unsigned LOW_MIN = 640 * QUARTER_DIV;
  localparam int unsigned GAP_MIN = 2 * QUARTER_DIV - 1;
  logic [15:0] low_cnt;
  logic [7:0]  scl_gap;
  always_ff @(posedge CLK_SYS) begin
    low_cnt <= CONFIG_DONE ? 16'h0000 : low_cnt + 16'h0001;
  end
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B || $changed(I2C_SCL)) scl_gap <= 8'h00;
    else if (scl_gap != 8'hFF) scl_gap <= scl_gap + 8'h01;
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  property p_reset_state;
    disable iff (1'b0)
    !RST_B |=> CONFIG_DONE && I2C_SCL && !I2C_SDA_OE && !ACK_ERROR;
  endproperty
  property p_launch_edge;
    $fell(CONFIG_DONE) |-> $past(INITIAL_ENABLE) ||
      ($past(CONFIGURE_REQUEST) && !$past(CONFIGURE_REQUEST, 2));
  endproperty
  property p_run_max;
    !CONFIG_DONE |-> low_cnt <= LOW_MAX;
  endproperty
  property p_run_min;
    $rose(CONFIG_DONE) |-> low_cnt >= LOW_MIN;
  endproperty
  property p_idle_bus;
    CONFIG_DONE |-> I2C_SCL && !I2C_SDA_OE;
  endproperty
  property p_sda_value;
    I2C_SDA_OUT == 1'b0;
  endproperty
  property p_apart;
    !($changed(I2C_SCL) && $changed(I2C_SDA_OE));
  endproperty
  property p_scl_rate;
    $changed(I2C_SCL) |-> scl_gap >= GAP_MIN;
  endproperty
  property p_nack_cause;
    $rose(ACK_ERROR) |->
      $past(I2C_SCL) && $past(I2C_SDA_IN) && !$past(I2C_SDA_OE);
  endproperty
  property p_err_clear;
    $fell(ACK_ERROR) |-> $fell(CONFIG_DONE);
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("outputs not idle in reset");
  a_launch_edge: assert property (p_launch_edge)
    else $error("run began without a request edge");
  a_run_max: assert property (p_run_max)
    else $error("run too long");
  a_run_min: assert property (p_run_min)
    else $error("run ended early");
  a_idle_bus: assert property (p_idle_bus)
    else $error("bus active while idle");
  a_sda_value: assert property (p_sda_value)
    else $error("data line driven high");
  a_apart: assert property (p_apart)
    else $error("clock and data moved together");
  a_scl_rate: assert property (p_scl_rate)
    else $error("serial clock too fast");
  a_nack_cause: assert property (p_nack_cause)
    else $error("ack error without a high ninth bit");
  a_err_clear: assert property (p_err_clear)
    else $error("ack error cleared outside a launch");
  c_run: cover property ($rose(CONFIG_DONE));
  c_nack: cover property ($rose(ACK_ERROR));
  c_init: cover property ($fell(CONFIG_DONE) && INITIAL_ENABLE);
endmodule
bind ocf_config_top ocf_config_props #(.QUARTER_DIV(QUARTER_DIV))
  ocf_config_props_i (
  .CLK_SYS(CLK_SYS), .RST_B(RST_B), .CONFIGURE_REQUEST(CONFIGURE_REQUEST),
  .FREQUENCY_SELECT(FREQUENCY_SELECT), .INITIAL_ENABLE(INITIAL_ENABLE),
  .CONFIG_DONE(CONFIG_DONE), .ACK_ERROR(ACK_ERROR), .I2C_SCL(I2C_SCL),
  .I2C_SDA_IN(I2C_SDA_IN), .I2C_SDA_OUT(I2C_SDA_OUT),
  .I2C_SDA_OE(I2C_SDA_OE));
`default_nettype wire

// [tb/ocf_osc_model.sv]
// Behavioural oscillator that acknowledges and records written bytes.
`timescale 1ns/10ps
`default_nettype none
module ocf_osc_model (
  // Bus
  input  wire logic scl,
  input  wire logic sda,
  // Control
  input  wire logic nack,
  output var  logic pull
);
  logic [7:0] shift;
  logic [7:0] bytes [$];
  int         bit_cnt = 0;
  int         frames = 0;
  initial pull = 1'b0;
  always @(negedge sda) begin
    if (scl) begin
      bit_cnt = -1;
      frames++;
    end
  end
  always @(posedge scl) begin
    if (bit_cnt >= 0 && bit_cnt < 8) shift = {shift[6:0], sda};
  end
  always @(negedge scl) begin
    bit_cnt++;
    if (bit_cnt == 8) begin
      bytes.push_back(shift);
      pull = !nack;
    end else if (bit_cnt == 9) begin
      pull = 1'b0;
      bit_cnt = 0;
    end
  end
endmodule
`default_nettype wire

// [tb/ocf_config_top_tb.sv]
// Directed bench for the oscillator configurator.
`timescale 1ns/10ps
`default_nettype none
module ocf_config_top_tb;
  localparam int unsigned QD = 2;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic        req = 1'b1;
  logic        init_en = 1'b1;
  logic        nack = 1'b0;
  logic [2:0]  sel = 3'h3;
  logic        done;
  logic        ack_err;
  logic        scl;
  logic        sda_out;
  logic        sda_oe;
  logic        pull;
  wire logic   sda;
  int          failures = 0;
  int          checks_done = 0;
  logic [2:0]  hs_t [8] = '{3'h5, 3'h7, 3'h5, 3'h7, 3'h5, 3'h0, 3'h0, 3'h5};
  logic [6:0]  n1_t [8] = '{7'h05, 7'h03, 7'h03, 7'h01, 7'h01, 7'h03, 7'h01,
                            7'h05};
  logic [37:0] rf_t [8] = '{38'h02F40135A9, 38'h0302013B65, 38'h0313814290,
    38'h0302013B65, 38'h0313814290, 38'h02D1E127AF, 38'h02D1E127AF,
    38'h02F40135A9};
  // Open-drain data line with a pull-up.
  assign sda = (sda_oe || pull) ? 1'b0 : 1'b1;
  always #25 clk_sys = ~clk_sys;
  ocf_config_top #(.QUARTER_DIV(QD)) ocf_config_top_i (
    .CLK_SYS(clk_sys), .RST_B(rst_b), .CONFIGURE_REQUEST(req),
    .FREQUENCY_SELECT(sel), .INITIAL_ENABLE(init_en), .CONFIG_DONE(done),
    .ACK_ERROR(ack_err), .I2C_SCL(scl), .I2C_SDA_IN(sda),
    .I2C_SDA_OUT(sda_out), .I2C_SDA_OE(sda_oe));
  ocf_osc_model ocf_osc_model_i (
    .scl(scl), .sda(sda), .nack(nack), .pull(pull));
  task automatic check(input logic [37:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      $display("ERROR %0t %s got %0h want %0h", $time, what, got, exp);
      failures++;
    end
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_done(input logic lvl);
    int n;
    n = 0;
    while (done !== lvl) begin
      @(negedge clk_sys);
      n++;
      if (n > 800 * QD) begin
        $display("ERROR %0t wait for done timed out", $time);
        failures++;
        finish_test();
      end
    end
  endtask
  task automatic check_run(input logic [2:0] m);
    logic [7:0] e [17];
    e = '{8'h00, 8'h89, 8'h10, 8'h00, 8'h07, {hs_t[m], n1_t[m][6:2]},
          {n1_t[m][1:0], rf_t[m][37:32]}, rf_t[m][31:24], rf_t[m][23:16],
          rf_t[m][15:8], rf_t[m][7:0], 8'h00, 8'h89, 8'h00, 8'h00, 8'h87,
          8'h40};
    check(38'(ocf_osc_model_i.frames), 38'h4, "frames");
    check(38'(ocf_osc_model_i.bytes.size()), 38'h11, "bytes");
    for (int i = 0; i < 17; i++) begin
      check(38'(ocf_osc_model_i.bytes[i]), 38'(e[i]), "byte");
    end
    ocf_osc_model_i.bytes.delete();
    ocf_osc_model_i.frames = 0;
  endtask
  // Kind 1 pokes a request mid-run, kind 2 resets mid-run.
  task automatic launch(input logic [2:0] m, input int kind);
    @(posedge clk_sys);
    sel <= m;
    req <= 1'b0;
    @(posedge clk_sys);
    req <= 1'b1;
    @(posedge clk_sys);
    req <= 1'b0;
    wait_done(1'b0);
    repeat (100) @(posedge clk_sys);
    if (kind == 1) begin
      req <= 1'b1;
      @(posedge clk_sys);
      req <= 1'b0;
    end
    if (kind == 2) begin
      rst_b <= 1'b0;
      repeat (4) @(negedge clk_sys);
      check(38'({done, scl, sda_oe}), 38'h6, "reset state");
      @(posedge clk_sys);
      rst_b <= 1'b1;
      ocf_osc_model_i.bytes.delete();
      ocf_osc_model_i.frames = 0;
    end
    wait_done(1'b1);
    repeat (20) @(negedge clk_sys);
    check(38'(done), 38'h1, "no relaunch");
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    check(38'(done), 38'h0, "default run");
    wait_done(1'b1);
    check_run(3'h3);
    repeat (20) @(negedge clk_sys);
    check(38'(done), 38'h1, "held request");
    @(posedge clk_sys);
    init_en <= 1'b0;
    for (int m = 0; m < 8; m++) begin
      launch(3'(m), (m == 5) ? 1 : 0);
      check_run(3'(m));
      check(38'(ack_err), 38'h0, "ack error");
    end
    launch(3'h4, 2);
    @(posedge clk_sys);
    nack <= 1'b1;
    launch(3'h2, 0);
    check(38'(ack_err), 38'h1, "nack");
    check_run(3'h2);
    @(posedge clk_sys);
    nack <= 1'b0;
    launch(3'h1, 0);
    check_run(3'h1);
    check(38'(ack_err), 38'h0, "nack cleared");
    finish_test();
  end
endmodule
`default_nettype wire
